/* mptl_map.svh */
// Register offsets, field positions, reset values and timing constants
`ifndef MPTL_MAP_SVH
`define MPTL_MAP_SVH

// Time base
`define MPTL_CLK_MHZ       40
`define MPTL_TICK_US       1000
`define MPTL_TICK_CYC      (`MPTL_TICK_US * `MPTL_CLK_MHZ)
`define MPTL_MS_TICKS(ms)  ((ms) * 1000 / `MPTL_TICK_US)

// Protection timing in milliseconds
`define MPTL_UNBAL_MS      5000
`define MPTL_THERM_MS      3000
`define MPTL_GF_STEP_MS    100
`define MPTL_FLASH_MS      250

// Protection thresholds
`define MPTL_LIGHT_PCT     40
`define MPTL_UNBAL_PCT     50
`define MPTL_STALL_SCALE   36000
`define MPTL_COOL_SHIFT    17

// Loop output in microamps
`define MPTL_LOOP_ZERO_UA  4000
`define MPTL_LOOP_SPAN_UA  16000

// Register offsets (byte addresses)
`define MPTL_CTRL_OFS      8'h00
`define MPTL_STATUS_OFS    8'h04
`define MPTL_IRQ_STAT_OFS  8'h08
`define MPTL_IRQ_MASK_OFS  8'h0c
`define MPTL_THERMAL_OFS   8'h10
`define MPTL_LOOP_OFS      8'h14

// Control fields and reset value
`define MPTL_CTRL_SWRST_BIT    0
`define MPTL_CTRL_UNBAL_EN_BIT 1
`define MPTL_CTRL_RESET        32'h0000_0002

// Cause bits in the interrupt registers; the status register carries only bits 0 to 3
`define MPTL_CAUSE_OVL     0
`define MPTL_CAUSE_UNBAL   1
`define MPTL_CAUSE_THERM   2
`define MPTL_CAUSE_GF      3
`define MPTL_CAUSE_TEST    4

`endif

/* mptl_pkg.sv */
// Types shared by the motor protection trip logic
package mptl_pkg;

	typedef enum logic {
		st_run,
		st_tripped
	} mptl_state_e;

	typedef logic [15:0] mptl_ms_t;

endpackage

/* mptl_tmr_if.sv */
// Link between the trip logic and one qualification timer
`timescale 1ns/1ps
`default_nettype none

interface mptl_tmr_if;
	logic              run;
	logic              tick;
	mptl_pkg::mptl_ms_t limit;
	logic              done;

	modport ctl (output run, output tick, output limit, input done);
	modport tmr (input run, input tick, input limit, output done);
endinterface

`default_nettype wire

/* mptl_qual_timer.sv */
// Qualification timer: condition must hold for a number of ticks
`timescale 1ns/1ps
`default_nettype none

module mptl_qual_timer (
	input  wire logic   core_clk_i,
	input  wire logic   rst_n_i,
	mptl_tmr_if.tmr     bus
);

	mptl_pkg::mptl_ms_t cnt;
	mptl_pkg::mptl_ms_t next_cnt;

	// Count only while the condition holds; a drop restarts timing
	always_comb begin
		next_cnt = cnt;
		if (!bus.run) begin
			next_cnt = '0;
		end else if (bus.tick && cnt < bus.limit) begin
			next_cnt = cnt + 16'h0001;
		end
	end

	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cnt <= '0;
		end else begin
			cnt <= next_cnt;
		end
	end

	// Zero limit means instantaneous once the condition is seen
	assign bus.done = bus.run && (cnt >= bus.limit);

endmodule // mptl_qual_timer

`default_nettype wire

/* mptl_trip.sv */
// Motor protection trip logic with APB register access
//
// Register access over APB and the placing of the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "mptl_map.svh"

// Function
// RULE_01 - Unbalance trips after five seconds, lights indicator
// RULE_02 - No unbalance trip below forty percent load
// RULE_03 - Ground fault at pickup level trips
// RULE_04 - Ground fault delay counted on crystal ticks
// RULE_05 - Hot thermistor above threshold leads to trip
// RULE_06 - Hot thermistor must persist three seconds
// RULE_07 - No-sensor condition suppresses thermistor trip
// RULE_08 - Loop output four plus sixteen times ratio
// RULE_09 - Loop output zero with no current
// RULE_10 - Self-test trips and sets four indicators
// RULE_11 - Overload light flashes at or above pickup
// RULE_12 - Thermal memory shortens later overload trips
// RULE_13 - Status light on while powered
// RULE_14 - Unbalance from average minus minimum ratio
// RULE_15 - Integrate squared current, trip on threshold
// RULE_16 - Thermal integral decays while not overloaded
// RULE_17 - When tripped ignore faults, await reset
// RULE_18 - Latch trip; test-then-reset clears memory
// RULE_19 - Panel settings sampled as static inputs
module mptl_trip #(
	parameter int unsigned AW       = 12,
	parameter int unsigned TICK_CYC = `MPTL_TICK_CYC,
	parameter int unsigned RATED    = 2048
) (
	input  wire logic          core_clk_i,
	input  wire logic          rst_n_i,
	input  wire logic [7:0]    paddr_i,
	input  wire logic          psel_i,
	input  wire logic          penable_i,
	input  wire logic          pwrite_i,
	input  wire logic [31:0]   pwdata_i,
	output logic      [31:0]   prdata_o,
	output logic               pready_o,
	output logic               pslverr_o,
	input  wire logic [AW-1:0] avg_amp_i,
	input  wire logic [AW-1:0] min_amp_i,
	input  wire logic [AW-1:0] gf_amp_i,
	input  wire logic [AW-1:0] full_load_i,
	input  wire logic [3:0]    stall_curve_setting_i,
	input  wire logic [AW-1:0] gf_pickup_i,
	input  wire logic [3:0]    gf_delay_i,
	input  wire logic          therm_hot_i,
	input  wire logic          therm_nosens_i,
	input  wire logic          test_btn_i,
	input  wire logic          reset_btn_i,
	output logic               trip_o,
	output logic               ovl_led_o,
	output logic               unbal_led_o,
	output logic               therm_led_o,
	output logic               gf_led_o,
	output logic               status_led_o,
	output logic      [15:0]   loop_ua_o,
	output logic               irq_o
);

	localparam int unsigned SW = 5 * AW + 12;

	logic [SW-1:0]          sync_a;
	logic [SW-1:0]          sync_b;
	logic [AW-1:0]          avg, min_a, gf, fl, gfp;
	logic [3:0]             stall, gfd;
	logic                   hot, nosens, test_b, rst_b;
	logic                   test_d, rst_d, test_rise, rst_rise;
	logic [23:0]            tick_cnt, next_tick_cnt;
	logic                   tick;
	logic [15:0]            flash_cnt, next_flash_cnt;
	logic                   flash, next_flash;
	logic [63:0]            acc, next_acc, sq, thr;
	logic                   light, unbal_cond, gf_cond, therm_cond;
	logic                   ovl_pick, ovl_trip;
	logic [2:0]             tmr_run, tmr_done;
	mptl_pkg::mptl_ms_t     tmr_lim [3];
	mptl_pkg::mptl_state_e  state, next_state;
	logic [3:0]             cause, next_cause;
	logic                   test_seen, next_test_seen;
	logic                   clear_mem, sw_reset;
	logic [31:0]            ctrl, next_ctrl;
	logic [4:0]             irq_stat, next_irq_stat, irq_mask, next_irq_mask;
	logic [4:0]             trip_evt;
	logic [31:0]            next_prdata, rd_mux;
	logic                   next_pready, next_pslverr, mapped, wr_acc;
	logic [15:0]            next_loop;
	logic                   next_trip, next_ovl_led, next_unbal_led;
	logic                   next_therm_led, next_gf_led, next_irq;
	logic [31:0]            loop_calc;

	////////////////////////////////////////////////////////////////////////
	// Input synchronisers; panel settings treated as static levels
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			sync_a <= '0;
			sync_b <= '0;
			test_d <= 1'b0;
			rst_d  <= 1'b0;
		end else begin
			sync_a <= {avg_amp_i, min_amp_i, gf_amp_i, full_load_i,
				stall_curve_setting_i, gf_pickup_i, gf_delay_i,
				therm_hot_i, therm_nosens_i, test_btn_i, reset_btn_i}; // RULE_19
			sync_b <= sync_a;
			test_d <= test_b;
			rst_d  <= rst_b;
		end
	end

	assign {avg, min_a, gf, fl, stall, gfp, gfd, hot, nosens, test_b,
		rst_b} = sync_b;
	assign test_rise = test_b && !test_d;
	assign rst_rise  = rst_b && !rst_d;

	////////////////////////////////////////////////////////////////////////
	// Millisecond tick from the crystal clock; drift free timing
	always_comb begin
		next_tick_cnt  = tick_cnt + 24'h000001;
		next_flash_cnt = flash_cnt;
		next_flash     = flash;
		if (tick) begin
			next_tick_cnt  = '0; // RULE_04
			next_flash_cnt = flash_cnt + 16'h0001;
			if (flash_cnt == 16'(`MPTL_MS_TICKS(`MPTL_FLASH_MS) - 1)) begin
				next_flash_cnt = '0;
				next_flash     = !flash;
			end
		end
	end

	assign tick = (tick_cnt == 24'(TICK_CYC - 1));

	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			tick_cnt  <= '0;
			flash_cnt <= '0;
			flash     <= 1'b0;
		end else begin
			tick_cnt  <= next_tick_cnt;
			flash_cnt <= next_flash_cnt;
			flash     <= next_flash;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Fault conditions from the digitised sensing
	always_comb begin
		light = (32'(avg) * 32'd100) <
			(32'(fl) * 32'(`MPTL_LIGHT_PCT)); // RULE_02
		unbal_cond = ctrl[`MPTL_CTRL_UNBAL_EN_BIT] && !light && avg > min_a
			&& (32'(avg - min_a) * 32'd100) >
			(32'(avg) * 32'(`MPTL_UNBAL_PCT)); // RULE_14
		gf_cond    = (gf != '0) && (gf >= gfp); // RULE_03
		therm_cond = hot && !nosens; // RULE_05 RULE_07
		ovl_pick   = (fl != '0) && (avg >= fl); // RULE_11
		sq         = 64'(avg) * 64'(avg);
		thr        = 64'(fl) * 64'(fl) * 64'(stall) *
			64'(`MPTL_STALL_SCALE); // RULE_12
		ovl_trip   = (thr != '0) && (acc >= thr); // RULE_15
	end

	////////////////////////////////////////////////////////////////////////
	// Thermal integral; decay gives roughly two minutes of memory
	always_comb begin
		next_acc = acc;
		if (clear_mem) begin
			next_acc = '0; // RULE_18
		end else if (tick && ovl_pick) begin
			next_acc = acc + sq; // RULE_15
		end else if (tick) begin
			next_acc = acc - (acc >> `MPTL_COOL_SHIFT); // RULE_16
		end
	end

	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			acc <= '0;
		end else begin
			acc <= next_acc;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Qualification timers: unbalance, ground fault, thermistor
	assign tmr_run = {therm_cond, gf_cond, unbal_cond} &
		{3{state == mptl_pkg::st_run}}; // RULE_17
	assign tmr_lim[0] = 16'(`MPTL_MS_TICKS(`MPTL_UNBAL_MS)); // RULE_01
	assign tmr_lim[1] = 16'(gfd) *
		16'(`MPTL_MS_TICKS(`MPTL_GF_STEP_MS)); // RULE_04
	assign tmr_lim[2] = 16'(`MPTL_MS_TICKS(`MPTL_THERM_MS)); // RULE_06

	mptl_tmr_if tmr_bus [3] ();

	for (genvar i = 0; i < 3; i++) begin : g_tmr
		assign tmr_bus[i].run   = tmr_run[i];
		assign tmr_bus[i].tick  = tick;
		assign tmr_bus[i].limit = tmr_lim[i];
		assign tmr_done[i]      = tmr_bus[i].done;
		mptl_qual_timer u_tmr (
			.core_clk_i (core_clk_i),
			.rst_n_i    (rst_n_i),
			.bus        (tmr_bus[i])
		);
	end

	////////////////////////////////////////////////////////////////////////
	// Trip state; causes latch until a reset request
	always_comb begin
		next_state     = state;
		next_cause     = cause;
		next_test_seen = test_seen;
		clear_mem      = 1'b0;
		trip_evt       = '0;
		unique case (state)
			mptl_pkg::st_run: begin
				if (test_rise) begin
					next_state     = mptl_pkg::st_tripped; // RULE_10
					next_cause     = 4'hf;
					next_test_seen = 1'b1;
					trip_evt       = 5'h1f;
				end else if (ovl_trip || (|tmr_done)) begin
					next_state = mptl_pkg::st_tripped; // RULE_18
					next_cause = {tmr_done[1], tmr_done[2], tmr_done[0],
						ovl_trip};
					trip_evt   = {1'b0, next_cause};
				end
			end
			mptl_pkg::st_tripped: begin
				// Faults ignored here; only a reset request is seen
				if (rst_rise || sw_reset) begin
					next_state     = mptl_pkg::st_run; // RULE_17
					next_cause     = '0;
					next_test_seen = 1'b0;
					clear_mem      = test_seen; // RULE_18
				end
			end
		endcase
	end

	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state     <= mptl_pkg::st_run;
			cause     <= '0;
			test_seen <= 1'b0;
		end else begin
			state     <= next_state;
			cause     <= next_cause;
			test_seen <= next_test_seen;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Output drive: trip relay, indicators and loop value
	always_comb begin
		loop_calc = 32'(`MPTL_LOOP_ZERO_UA) + (32'(avg) *
			32'(`MPTL_LOOP_SPAN_UA)) / 32'(RATED); // RULE_08
		next_loop = (avg == '0) ? 16'h0000 : loop_calc[15:0]; // RULE_09
		next_trip      = (next_state == mptl_pkg::st_tripped);
		next_ovl_led   = next_cause[`MPTL_CAUSE_OVL] ||
			((next_state == mptl_pkg::st_run) && ovl_pick && flash); // RULE_11
		next_unbal_led = next_cause[`MPTL_CAUSE_UNBAL]; // RULE_01
		next_therm_led = next_cause[`MPTL_CAUSE_THERM];
		next_gf_led    = next_cause[`MPTL_CAUSE_GF];
	end

	// Status light goes on at the first edge and stays on
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			trip_o       <= 1'b0;
			ovl_led_o    <= 1'b0;
			unbal_led_o  <= 1'b0;
			therm_led_o  <= 1'b0;
			gf_led_o     <= 1'b0;
			status_led_o <= 1'b0;
			loop_ua_o    <= '0;
		end else begin
			trip_o       <= next_trip;
			ovl_led_o    <= next_ovl_led;
			unbal_led_o  <= next_unbal_led;
			therm_led_o  <= next_therm_led;
			gf_led_o     <= next_gf_led;
			status_led_o <= 1'b1; // RULE_13
			loop_ua_o    <= next_loop;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// APB slave: data and ready prepared in setup, one access cycle
	assign wr_acc   = psel_i && penable_i && pready_o && pwrite_i;
	assign sw_reset = wr_acc && (paddr_i == `MPTL_CTRL_OFS) &&
		pwdata_i[`MPTL_CTRL_SWRST_BIT];

	always_comb begin
		mapped = 1'b1;
		rd_mux = '0;
		unique case (paddr_i)
			`MPTL_CTRL_OFS:     rd_mux = {ctrl[31:1], 1'b0};
			`MPTL_STATUS_OFS:   rd_mux = {24'h0, test_seen, ovl_pick,
				(state == mptl_pkg::st_tripped), 1'b0, cause};
			`MPTL_IRQ_STAT_OFS: rd_mux = {27'h0, irq_stat};
			`MPTL_IRQ_MASK_OFS: rd_mux = {27'h0, irq_mask};
			`MPTL_THERMAL_OFS:  rd_mux = acc[47:16];
			`MPTL_LOOP_OFS:     rd_mux = {16'h0, loop_ua_o};
			default:            mapped = 1'b0;
		endcase
		next_pready  = psel_i && !penable_i;
		next_pslverr = next_pready && !mapped;
		next_prdata  = next_pready ? rd_mux : prdata_o;
		next_ctrl     = ctrl;
		next_irq_mask = irq_mask;
		next_irq_stat = irq_stat;
		if (wr_acc && paddr_i == `MPTL_CTRL_OFS) begin
			next_ctrl = pwdata_i & 32'h0000_0002;
		end
		if (wr_acc && paddr_i == `MPTL_IRQ_MASK_OFS) begin
			next_irq_mask = pwdata_i[4:0];
		end
		if (wr_acc && paddr_i == `MPTL_IRQ_STAT_OFS) begin
			next_irq_stat = irq_stat & ~pwdata_i[4:0];
		end
		// Set after clear so an event in the clear cycle survives
		next_irq_stat = next_irq_stat | trip_evt;
		next_irq      = |(next_irq_stat & next_irq_mask);
	end

	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			prdata_o  <= '0;
			pready_o  <= 1'b0;
			pslverr_o <= 1'b0;
			ctrl      <= `MPTL_CTRL_RESET;
			irq_stat  <= '0;
			irq_mask  <= '0;
			irq_o     <= 1'b0;
		end else begin
			prdata_o  <= next_prdata;
			pready_o  <= next_pready;
			pslverr_o <= next_pslverr;
			ctrl      <= next_ctrl;
			irq_stat  <= next_irq_stat;
			irq_mask  <= next_irq_mask;
			irq_o     <= next_irq;
		end
	end

endmodule // mptl_trip

`default_nettype wire

/* mptl_plant.sv */
// Plant model: current sensors, thermistor divider and contactor
`timescale 1ns/1ps
`default_nettype none

module mptl_plant #(
	parameter int unsigned AW = 12
) (
	input  wire logic [AW-1:0] load_i,
	input  wire logic          lost_phase_i,
	input  wire logic [AW-1:0] leak_i,
	input  wire logic          hot_i,
	input  wire logic          absent_i,
	input  wire logic          trip_i,
	output logic      [AW-1:0] avg_o,
	output logic      [AW-1:0] min_o,
	output logic      [AW-1:0] gf_o,
	output logic               hot_o,
	output logic               nosens_o
);
	// Open contactor stops all phase and leak current
	assign avg_o = trip_i ? '0 : load_i;
	assign min_o = (trip_i || lost_phase_i) ? '0 : load_i;
	assign gf_o  = trip_i ? '0 : leak_i;
	// Missing sensor sits above both divider thresholds
	assign hot_o    = hot_i || absent_i;
	assign nosens_o = absent_i;
endmodule // mptl_plant

`default_nettype wire

/* mptl_trip_assertions.sv */
// Port checker for the motor protection trip logic
`timescale 1ns/1ps
`default_nettype none

module mptl_trip_assertions #(
	parameter int unsigned AW    = 12,
	parameter int unsigned RATED = 2048
) (
	input wire logic          core_clk_i,
	input wire logic          rst_n_i,
	input wire logic          psel_i,
	input wire logic [AW-1:0] avg_amp_i,
	input wire logic [AW-1:0] full_load_i,
	input wire logic          therm_hot_i,
	input wire logic          therm_nosens_i,
	input wire logic          test_btn_i,
	input wire logic          reset_btn_i,
	input wire logic          trip_o,
	input wire logic          ovl_led_o,
	input wire logic          unbal_led_o,
	input wire logic          therm_led_o,
	input wire logic          gf_led_o,
	input wire logic          status_led_o,
	input wire logic [15:0]   loop_ua_o
);
	logic [3:0] calm;
	logic [3:0] next_calm;
	logic       all_led;
	logic       light_ok;

	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (!rst_n_i);

	////////////////////////////////////////////////////////////////////////
	// Cycles since a reset request could last have arrived
	always_comb begin
		next_calm = (calm == 4'hf) ? calm : calm + 4'h1;
		if (reset_btn_i || psel_i)
			next_calm = 4'h0;
	end
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i)
			calm <= 4'h0;
		else
			calm <= next_calm;
	end
	// Wide compare, so the percentage never overflows
	assign light_ok = 32'(avg_amp_i) * 32'h5 >= 32'(full_load_i) * 32'h2;
	assign all_led  = trip_o && ovl_led_o && unbal_led_o && therm_led_o
		&& gf_led_o;

	////////////////////////////////////////////////////////////////////////
	a_status_lit: assert property ($past(rst_n_i) |-> status_led_o)
		else $error("status light dark while powered");
	a_trip_latched: assert property ($fell(trip_o) |-> calm < 4'h6)
		else $error("trip released without a reset request");
	a_loop_dead: assert property ((avg_amp_i == '0)[*8] |->
		loop_ua_o == 16'h0000) else $error("loop output not zero");
	a_loop_rated: assert property ((avg_amp_i == AW'(RATED))[*8] |->
		loop_ua_o == 16'h4e20) else $error("loop output wrong at rated");
	a_test_sets: assert property ($rose(test_btn_i) && !trip_o |->
		##[1:8] all_led) else $error("self test missed an indicator");
	a_light_inhibit: assert property ($rose(unbal_led_o) && !gf_led_o |->
		$past(light_ok, 4)) else $error("unbalance trip at light load");
	a_therm_holdoff: assert property ($rose(therm_led_o) && !gf_led_o |->
		$past(therm_hot_i, 4) && !$past(therm_nosens_i, 4))
		else $error("thermistor trip without valid hot sensor");
	a_ovl_dark: assert property ((avg_amp_i < full_load_i && !trip_o)[*8]
		|-> !ovl_led_o) else $error("overload light on below pickup");

	c_trip: cover property ($rose(trip_o));
	c_unbal: cover property ($rose(unbal_led_o));
	c_release: cover property ($fell(trip_o));
endmodule // mptl_trip_assertions

bind mptl_trip mptl_trip_assertions #(.AW(AW), .RATED(RATED)) u_chk (
	.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .psel_i(psel_i),
	.avg_amp_i(avg_amp_i), .full_load_i(full_load_i),
	.therm_hot_i(therm_hot_i), .therm_nosens_i(therm_nosens_i),
	.test_btn_i(test_btn_i), .reset_btn_i(reset_btn_i), .trip_o(trip_o),
	.ovl_led_o(ovl_led_o), .unbal_led_o(unbal_led_o),
	.therm_led_o(therm_led_o), .gf_led_o(gf_led_o),
	.status_led_o(status_led_o), .loop_ua_o(loop_ua_o));

`default_nettype wire

/* tb_motor_protection_trip_logic.sv */
// Self-checking bench for the motor protection trip logic
`timescale 1ns/1ps
`default_nettype none

module tb_motor_protection_trip_logic;
	localparam int TK = 4;
	typedef struct packed {logic [11:0] avg; logic [15:0] loop;} mptl_row_s;
	mptl_row_s   rows [4] = '{'{12'h000, 16'h0000}, '{12'h800, 16'h4e20},
		'{12'h400, 16'h2ee0}, '{12'h200, 16'h1f40}};
	logic        clk = 1'h0, rst_n = 1'h0, psel = 1'h0, penable = 1'h0;
	logic        pwrite = 1'h0, lost = 1'h0, hot = 1'h0, absent = 1'h0;
	logic        test = 1'h0, rbtn = 1'h0, pready, pslverr, e;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, q;
	logic [11:0] load = 12'h0, leak = 12'h0, fl = 12'hbb8, avg, mn, gf;
	logic [3:0]  gfd = 4'h0, stall = 4'h1;
	logic        th, ns, trip, ovl, unb, thl, gfl, st, irq;
	logic [15:0] loop;
	int          fails = 0, checked = 0, cyc = 0, n;

	mptl_trip #(.TICK_CYC(TK)) dut (.core_clk_i(clk), .rst_n_i(rst_n),
		.paddr_i(paddr), .psel_i(psel), .penable_i(penable),
		.pwrite_i(pwrite), .pwdata_i(pwdata), .prdata_o(prdata),
		.pready_o(pready), .pslverr_o(pslverr), .avg_amp_i(avg),
		.min_amp_i(mn), .gf_amp_i(gf), .full_load_i(fl),
		.stall_curve_setting_i(stall), .gf_pickup_i(12'h100),
		.gf_delay_i(gfd), .therm_hot_i(th), .therm_nosens_i(ns),
		.test_btn_i(test), .reset_btn_i(rbtn), .trip_o(trip),
		.ovl_led_o(ovl), .unbal_led_o(unb), .therm_led_o(thl),
		.gf_led_o(gfl), .status_led_o(st), .loop_ua_o(loop), .irq_o(irq));
	mptl_plant plant (.load_i(load), .lost_phase_i(lost), .leak_i(leak),
		.hot_i(hot), .absent_i(absent), .trip_i(trip), .avg_o(avg),
		.min_o(mn), .gf_o(gf), .hot_o(th), .nosens_o(ns));

	////////////////////////////////////////////////////////////////////////
	// Clock, and a hang limit well past the longest scenario
	initial forever #12.5 clk = ~clk;
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 90000) begin
			fails++;
			summarize();
		end
	end

	task automatic chk(input string nm, input logic [31:0] x,
		input logic [31:0] g);
		checked++;
		if (g !== x) begin
			$display("[ERR] %s expected %h seen %h", nm, x, g);
			fails++;
		end
	endtask
	// One APB transfer; result lands in q and e
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		int k;
		k = 0;
		@(posedge clk);
		psel <= 1'h1;
		paddr <= a;
		pwrite <= w;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'h1;
		do begin
			@(posedge clk);
			k++;
		end while (pready !== 1'h1 && k < 20);
		q = prdata;
		e = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
		chk("pready", 1'h1, pready);
	endtask
	task automatic tk(input int t);
		repeat (t * TK) @(posedge clk);
	endtask
	// Bounded wait; the caller judges the outcome
	task automatic wt(input int t);
		for (int i = 0; i < t && trip !== 1'h1; i++)
			@(posedge clk);
	endtask
	task automatic clr;
		@(posedge clk) rbtn <= 1'h1;
		repeat (8) @(posedge clk);
		rbtn <= 1'h0;
		repeat (4) @(posedge clk);
	endtask
	task automatic summarize;
		$display("checked %0d fails %0d", checked, fails);
		if (fails == 0 && checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (4) @(posedge clk);
		rst_n <= 1'h1;
		repeat (2) @(posedge clk);
		chk("status_led", 1'h1, st);
		apb(1'h0, 8'h00, 32'h0);
		chk("ctrl", 32'h2, q);
		apb(1'h0, 8'h0c, 32'h0);
		chk("irq_mask", 32'h0, q);
		apb(1'h0, 8'h1c, 32'h0);
		chk("unmapped_err", 32'h1, {31'h0, e});
		chk("unmapped_rd", 32'h0, q);
		foreach (rows[i]) begin
			@(posedge clk) load <= rows[i].avg;
			repeat (10) @(posedge clk);
			chk("loop_ua", rows[i].loop, loop);
			chk("ovl_off", 1'h0, ovl);
		end
		// Overload pickup: light must flash, memory must fill
		@(posedge clk) fl <= 12'h3e8;
		load <= 12'h44c;
		n = 0;
		repeat (2500) @(posedge clk) n += ovl;
		chk("ovl_flash", 1'h1, n > 0 && n < 2500);
		apb(1'h0, 8'h10, 32'h0);
		chk("thermal_up", 1'h1, q !== 32'h0);
		// Self test, then the interrupt masked, unmasked, cleared
		@(posedge clk) load <= 12'h0;
		test <= 1'h1;
		repeat (10) @(posedge clk);
		chk("test_leds", 5'h1f, {trip, ovl, unb, thl, gfl});
		chk("irq_masked", 1'h0, irq);
		apb(1'h1, 8'h0c, 32'h10);
		// Interrupt line is registered; look one edge after the write
		@(posedge clk);
		chk("irq_on", 1'h1, irq);
		apb(1'h1, 8'h08, 32'h1f);
		@(posedge clk);
		chk("irq_clear", 1'h0, irq);
		@(posedge clk) test <= 1'h0;
		clr();
		chk("reset_trip", 1'h0, trip);
		apb(1'h0, 8'h10, 32'h0);
		chk("thermal_clr", 32'h0, q);
		// Thermistor: hold-off, then three second delay
		@(posedge clk) absent <= 1'h1;
		tk(3100);
		chk("nosens", 1'h0, trip);
		@(posedge clk) absent <= 1'h0;
		hot <= 1'h1;
		tk(2990);
		chk("hot_early", 1'h0, trip);
		wt(200);
		chk("hot_trip", 2'h3, {trip, thl});
		@(posedge clk) test <= 1'h1;
		repeat (10) @(posedge clk);
		chk("tripped_test", 1'h0, unb);
		@(posedge clk) test <= 1'h0;
		hot <= 1'h0;
		apb(1'h1, 8'h00, 32'h3);
		repeat (4) @(posedge clk);
		chk("sw_reset", 1'h0, trip);
		// Ground fault 25% over pickup, immediate then delayed
		@(posedge clk) leak <= 12'h140;
		wt(40);
		chk("gf_trip", 2'h3, {trip, gfl});
		@(posedge clk) leak <= 12'h0;
		gfd <= 4'h2;
		clr();
		@(posedge clk) leak <= 12'h140;
		tk(190);
		chk("gf_early", 1'h0, trip);
		wt(100);
		chk("gf_delay", 1'h1, trip);
		@(posedge clk) leak <= 12'h0;
		clr();
		// Lost phase: ignored at light load, trips near full load
		@(posedge clk) fl <= 12'h7d0;
		load <= 12'h2bc;
		lost <= 1'h1;
		tk(5100);
		chk("light_load", 1'h0, trip);
		@(posedge clk) load <= 12'h76c;
		tk(4950);
		chk("unbal_early", 1'h0, trip);
		wt(400);
		chk("unbal_trip", 2'h3, {trip, unb});
		// Overload: empty memory needs 500 ticks at twelve times pickup
		@(posedge clk) lost <= 1'h0;
		load <= 12'h0;
		clr();
		@(posedge clk) fl <= 12'h100;
		stall <= 4'h2;
		load <= 12'hc00;
		tk(480);
		chk("ovl_early", 1'h0, trip);
		wt(200);
		chk("ovl_trip", 2'h3, {trip, ovl});
		// Plain reset keeps the heat, so the next trip comes at once
		clr();
		tk(20);
		chk("ovl_memory", 1'h1, trip);
		summarize();
	end
endmodule // tb_motor_protection_trip_logic

`default_nettype wire
